// >>> include/wwd_pkg.sv
// Shared constants and types for the window supervisor with clock monitor.
// Assumes a 200 MHz system clock and an instruction cycle derived from the CKI pin.
package wwd_pkg;
    localparam int CLK_FREQ_HZ = 200_000_000;
    // CKI rising edges per instruction cycle
    localparam int CKI_PER_TC = 10;

    // Service register field layout
    localparam int SVR_WIN_HI = 7;
    localparam int SVR_WIN_LO = 6;
    localparam int SVR_KEY_HI = 5;
    localparam int SVR_KEY_LO = 1;
    localparam int SVR_CM_BIT = 0;
    localparam logic [4:0] SVR_KEY = 5'h0C;
    localparam logic [4:0] SVR_KEY_READ = 5'h00;
    localparam logic [1:0] SVR_WIN_RST = 2'h3;
    localparam logic SVR_CM_RST = 1'b1;

    // Window limits in instruction cycles
    localparam int WIN_W = 17;
    localparam logic [16:0] WIN_LOWER = 17'h0_0800;
    localparam logic [16:0] WIN_UPPER_MIN = 17'h0_2000;

    // Fault pin held this many instruction cycles after it is seen low
    localparam int FAULT_HOLD_TC = 16;
    localparam int HOLD_W = 5;

    // Clock monitor: reject when no instruction cycle arrives within this time
    localparam int CM_TIMEOUT_US = 1000;
    localparam int CM_TIMEOUT_CYC = (CLK_FREQ_HZ / 1_000_000) * CM_TIMEOUT_US;

    typedef enum logic [1:0] {
        WWD_RUN = 2'b00,
        WWD_DRIVE = 2'b01,
        WWD_HOLD = 2'b10,
        WWD_RELEASE = 2'b11
    } wwd_fault_st_t;
endpackage

// >>> include/wwd_cm_if.sv
// Link between the supervisor core and its clock monitor.
// Both ends run on the same system clock.
`timescale 1ns/10ps
interface wwd_cm_if;
    logic tc_tick;
    logic enable;
    logic err;
    modport mon (input tc_tick, input enable, output err);
    modport ctl (output tc_tick, output enable, input err);
endinterface

// >>> hdl/wwd_clk_mon.sv
// Clock monitor: flags a missing or too slow instruction cycle clock.
// Assumes tc_tick is a one-cycle pulse per instruction cycle on clk_i.
`timescale 1ns/10ps
module wwd_clk_mon #(
    parameter int TIMEOUT_CYC = wwd_pkg::CM_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    wwd_cm_if.mon cm
);
    localparam int GAP_W = $clog2(TIMEOUT_CYC + 1);

    if (TIMEOUT_CYC < 2) begin : g_chk
        $error("wwd_clk_mon: TIMEOUT_CYC must be at least 2");
    end

    logic [GAP_W-1:0] gap_ff;
    logic [GAP_W-1:0] nxt_gap_ff;
    logic err_ff;
    logic nxt_err_ff;

    // A 1 ms limit sits between the never-reject and always-reject rates
    always_comb begin
        nxt_gap_ff = gap_ff;
        nxt_err_ff = err_ff;
        if (!cm.enable) begin
            nxt_gap_ff = '0;
            nxt_err_ff = 1'b0;
        end else if (cm.tc_tick) begin
            nxt_gap_ff = '0;
            nxt_err_ff = 1'b0;
        end else if (gap_ff == GAP_W'(TIMEOUT_CYC - 1)) begin
            nxt_err_ff = 1'b1;
        end else begin
            nxt_gap_ff = gap_ff + GAP_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_ff <= '0;
            err_ff <= 1'b0;
        end else begin
            gap_ff <= nxt_gap_ff;
            err_ff <= nxt_err_ff;
        end
    end

    assign cm.err = err_ff;
endmodule

// >>> hdl/wwd_top.sv
// Window supervisor with clock monitor and open-drain fault pin.
// Assumes CKI arrives as a raw pin, halt/idle come from the CPU on clk_i,
// and the fault pin has an outside pull-up.
`timescale 1ns/10ps
module wwd_top #(
    parameter int CKI_PER_TC = wwd_pkg::CKI_PER_TC,
    parameter int CM_TIMEOUT_CYC = wwd_pkg::CM_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cki_i,
    input wire logic svr_wr_i,
    input wire logic [7:0] svr_wdata_i,
    output logic [7:0] svr_rdata_o,
    input wire logic halt_i,
    input wire logic idle_i,
    input wire logic rc_osc_option_i,
    input wire logic restart_delay_select_i,
    input wire logic fault_pin_i,
    output logic fault_pin_o,
    output logic fault_pin_oe_o
);
    localparam int DIV_W = $clog2(CKI_PER_TC + 1);

    if (CKI_PER_TC < 1) begin : g_chk
        $error("wwd_top: CKI_PER_TC must be at least 1");
    end

    wwd_cm_if cm_if ();

    // Pin synchronisers
    logic cki_s1_ff;
    logic cki_s2_ff;
    logic cki_s3_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cki_s1_ff <= 1'b0;
            cki_s2_ff <= 1'b0;
            cki_s3_ff <= 1'b0;
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            cki_s1_ff <= cki_i;
            cki_s2_ff <= cki_s1_ff;
            cki_s3_ff <= cki_s2_ff;
            pin_s1_ff <= fault_pin_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Instruction cycle enable from CKI edges; stops when CKI stops
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div_ff;
    logic tick_ff;
    logic nxt_tick_ff;

    always_comb begin
        nxt_div_ff = div_ff;
        nxt_tick_ff = 1'b0;
        if (cki_s2_ff && !cki_s3_ff) begin
            if (div_ff == DIV_W'(CKI_PER_TC - 1)) begin
                nxt_div_ff = '0;
                nxt_tick_ff = 1'b1;
            end else begin
                nxt_div_ff = div_ff + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div_ff;
            tick_ff <= nxt_tick_ff;
        end
    end

    // Supervisor state
    logic cfg_done_ff;
    logic nxt_cfg_done_ff;
    logic [1:0] win_sel_ff;
    logic [1:0] nxt_win_sel_ff;
    logic cm_en_ff;
    logic nxt_cm_en_ff;
    logic [wwd_pkg::WIN_W-1:0] cnt_ff;
    logic [wwd_pkg::WIN_W-1:0] nxt_cnt_ff;
    logic [wwd_pkg::HOLD_W-1:0] hold_ff;
    logic [wwd_pkg::HOLD_W-1:0] nxt_hold_ff;
    wwd_pkg::wwd_fault_st_t st_ff;
    wwd_pkg::wwd_fault_st_t nxt_st_ff;
    logic halt_q_ff;
    logic idle_q_ff;
    logic oe_ff;
    logic nxt_oe_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata_ff;

    logic [4:0] wr_key;
    logic [1:0] wr_win;
    logic wr_cm;
    logic key_ok;
    logic svc_ok;
    logic cm_active;
    logic sw_err;
    logic [wwd_pkg::WIN_W-1:0] upper;

    assign cm_if.tc_tick = tick_ff;
    assign cm_if.enable = cm_en_ff;

    wwd_clk_mon #(
        .TIMEOUT_CYC(CM_TIMEOUT_CYC)
    ) u_clk_mon (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cm(cm_if.mon)
    );

    always_comb begin
        wr_key = svr_wdata_i[wwd_pkg::SVR_KEY_HI:wwd_pkg::SVR_KEY_LO];
        wr_win = svr_wdata_i[wwd_pkg::SVR_WIN_HI:wwd_pkg::SVR_WIN_LO];
        wr_cm = svr_wdata_i[wwd_pkg::SVR_CM_BIT];
        key_ok = (wr_key == wwd_pkg::SVR_KEY);
        svc_ok = key_ok && (wr_win == win_sel_ff) && (wr_cm == cm_en_ff);
        upper = wwd_pkg::WIN_UPPER_MIN << win_sel_ff;
        cm_active = cm_if.err && cm_en_ff;
        sw_err = 1'b0;

        nxt_cfg_done_ff = cfg_done_ff;
        nxt_win_sel_ff = win_sel_ff;
        nxt_cm_en_ff = cm_en_ff;
        nxt_cnt_ff = cnt_ff;

        // Window logic runs only while the pin is not driven
        if (st_ff == wwd_pkg::WWD_RUN) begin
            if (svr_wr_i) begin
                if (!cfg_done_ff) begin
                    if (key_ok) begin
                        nxt_cfg_done_ff = 1'b1;
                        nxt_win_sel_ff = wr_win;
                        nxt_cm_en_ff = wr_cm;
                        nxt_cnt_ff = '0;
                    end else begin
                        sw_err = 1'b1;
                    end
                end else if (svc_ok && cnt_ff >= wwd_pkg::WIN_LOWER) begin
                    nxt_cnt_ff = '0;
                end else begin
                    sw_err = 1'b1;
                end
            end else if (idle_q_ff && !idle_i) begin
                nxt_cnt_ff = '0;
            end else if (halt_q_ff && !halt_i) begin
                if (!rc_osc_option_i || restart_delay_select_i) begin
                    nxt_cnt_ff = '0;
                end
            end else if (tick_ff && !halt_i && !idle_i) begin
                if (cnt_ff + wwd_pkg::WIN_W'(1) == upper) begin
                    sw_err = 1'b1;
                end else begin
                    nxt_cnt_ff = cnt_ff + wwd_pkg::WIN_W'(1);
                end
            end
        end else if (st_ff == wwd_pkg::WWD_RELEASE && pin_s2_ff && !cm_active) begin
            nxt_cnt_ff = '0;
        end
    end

    // Fault pin sequencing
    always_comb begin
        nxt_st_ff = st_ff;
        nxt_hold_ff = hold_ff;
        case (st_ff)
            wwd_pkg::WWD_RUN: begin
                if (sw_err || cm_active) begin
                    nxt_st_ff = wwd_pkg::WWD_DRIVE;
                end
            end
            wwd_pkg::WWD_DRIVE: begin
                if (!pin_s2_ff) begin
                    nxt_st_ff = wwd_pkg::WWD_HOLD;
                    nxt_hold_ff = '0;
                end
            end
            wwd_pkg::WWD_HOLD: begin
                if (cm_active) begin
                    nxt_hold_ff = '0;
                end else if (tick_ff) begin
                    // One extra tick: the first may follow entry at once, short of 16 tc
                    if (hold_ff == wwd_pkg::HOLD_W'(wwd_pkg::FAULT_HOLD_TC)) begin
                        nxt_st_ff = wwd_pkg::WWD_RELEASE;
                    end else begin
                        nxt_hold_ff = hold_ff + wwd_pkg::HOLD_W'(1);
                    end
                end
            end
            wwd_pkg::WWD_RELEASE: begin
                if (cm_active) begin
                    nxt_st_ff = wwd_pkg::WWD_DRIVE;
                end else if (pin_s2_ff) begin
                    nxt_st_ff = wwd_pkg::WWD_RUN;
                end
            end
            default: begin
                nxt_st_ff = wwd_pkg::WWD_RUN;
            end
        endcase
        nxt_oe_ff = (nxt_st_ff == wwd_pkg::WWD_DRIVE) || (nxt_st_ff == wwd_pkg::WWD_HOLD);
        nxt_rdata_ff = {nxt_win_sel_ff, wwd_pkg::SVR_KEY_READ, nxt_cm_en_ff};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_done_ff <= 1'b0;
            win_sel_ff <= wwd_pkg::SVR_WIN_RST;
            cm_en_ff <= wwd_pkg::SVR_CM_RST;
            cnt_ff <= '0;
            hold_ff <= '0;
            st_ff <= wwd_pkg::WWD_RUN;
            halt_q_ff <= 1'b0;
            idle_q_ff <= 1'b0;
            oe_ff <= 1'b0;
            rdata_ff <= {wwd_pkg::SVR_WIN_RST, wwd_pkg::SVR_KEY_READ, wwd_pkg::SVR_CM_RST};
        end else begin
            cfg_done_ff <= nxt_cfg_done_ff;
            win_sel_ff <= nxt_win_sel_ff;
            cm_en_ff <= nxt_cm_en_ff;
            cnt_ff <= nxt_cnt_ff;
            hold_ff <= nxt_hold_ff;
            st_ff <= nxt_st_ff;
            halt_q_ff <= halt_i;
            idle_q_ff <= idle_i;
            oe_ff <= nxt_oe_ff;
            rdata_ff <= nxt_rdata_ff;
        end
    end

    // Open drain: only ever drives low
    logic drive_lvl_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_lvl_ff <= 1'b0;
        end else begin
            drive_lvl_ff <= 1'b0;
        end
    end

    assign fault_pin_o = drive_lvl_ff;
    assign fault_pin_oe_o = oe_ff;
    assign svr_rdata_o = rdata_ff;
endmodule

// >>> tb/wwd_pullup.sv
// Outside pull-up on the open-drain fault pin.
// Assumes the device pulls low only while its enable is high.
`timescale 1ns/10ps
module wwd_pullup (
    input wire logic drv_i,
    input wire logic oe_i,
    output logic pin_o
);
    // A released pin rises at once; a slow rise only delays the restart
    assign pin_o = oe_i ? drv_i : 1'b1;
endmodule

// >>> tb/wwd_top_properties.sv
// Port checker for the window supervisor top.
// Assumes one clock domain; bound to every wwd_top below.
`timescale 1ns/10ps
module wwd_top_properties #(
    parameter int CKI_PER_TC = wwd_pkg::CKI_PER_TC,
    parameter int CM_TIMEOUT_CYC = wwd_pkg::CM_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cki_i,
    input wire logic svr_wr_i,
    input wire logic [7:0] svr_wdata_i,
    input wire logic [7:0] svr_rdata_o,
    input wire logic halt_i,
    input wire logic idle_i,
    input wire logic rc_osc_option_i,
    input wire logic restart_delay_select_i,
    input wire logic fault_pin_i,
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe_o
);
    // No edge at all for this long means no instruction cycle either
    localparam int MON_LIM = CM_TIMEOUT_CYC + 8;
    logic [15:0] hold_ff, nxt_hold;
    logic [19:0] idle_ff, nxt_idle;
    logic cki_ff, nxt_cki;
    always_comb begin
        nxt_hold = fault_pin_oe_o ? hold_ff + 16'h0001 : 16'h0000;
        nxt_idle = (cki_i != cki_ff) ? 20'h0_0000 : idle_ff + 20'h0_0001;
        nxt_cki = cki_i;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_ff <= 16'h0000;
            idle_ff <= 20'h0_0000;
            cki_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
            idle_ff <= nxt_idle;
            cki_ff <= nxt_cki;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet;
        !fault_pin_oe_o [*6];
    endsequence
    sequence s_bad_wr;
        svr_wr_i && (svr_wdata_i[5:1] != wwd_pkg::SVR_KEY);
    endsequence
    property p_reset_val;
        $rose(rst_n_i) |-> svr_rdata_o == 8'hC1 && !fault_pin_oe_o;
    endproperty
    property p_key_read;
        svr_rdata_o[5:1] == 5'h00;
    endproperty
    property p_pin_low;
        fault_pin_oe_o |-> fault_pin_o == 1'b0;
    endproperty
    property p_bad_key;
        (s_quiet ##0 s_bad_wr) |=> fault_pin_oe_o;
    endproperty
    property p_one_time;
        svr_rdata_o != 8'hC1 |=> $stable(svr_rdata_o);
    endproperty
    property p_ignore;
        fault_pin_oe_o && svr_wr_i |=> $stable(svr_rdata_o) && fault_pin_oe_o;
    endproperty
    property p_hold;
        $fell(fault_pin_oe_o) |-> $past(hold_ff) >= 16'h001E;
    endproperty
    property p_clk_mon;
        idle_ff == 20'(MON_LIM) && svr_rdata_o[0] |-> ##[0:8] fault_pin_oe_o;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset state");
    a_key_read: assert property (p_key_read) else $error("key readable");
    a_pin_low: assert property (p_pin_low) else $error("pin not driven low");
    a_bad_key: assert property (p_bad_key) else $error("bad key accepted");
    a_one_time: assert property (p_one_time) else $error("config changed");
    a_ignore: assert property (p_ignore) else $error("write not ignored");
    a_hold: assert property (p_hold) else $error("hold too short");
    a_clk_mon: assert property (p_clk_mon) else $error("stopped clock missed");
endmodule
bind wwd_top wwd_top_properties #(.CKI_PER_TC(CKI_PER_TC), .CM_TIMEOUT_CYC(CM_TIMEOUT_CYC))
    wwd_top_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cki_i(cki_i),
    .svr_wr_i(svr_wr_i), .svr_wdata_i(svr_wdata_i), .svr_rdata_o(svr_rdata_o),
    .halt_i(halt_i), .idle_i(idle_i), .rc_osc_option_i(rc_osc_option_i),
    .restart_delay_select_i(restart_delay_select_i), .fault_pin_i(fault_pin_i),
    .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o));

// >>> tb/testbench.sv
// Self-checking bench for the window supervisor with clock monitor.
// Assumes CKI toggles every clock, so one instruction cycle is two clocks.
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] CFG = 8'h19;
    localparam int GAP = 4300;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cki_i = 1'b0;
    logic cki_run = 1'b1;
    logic svr_wr_i = 1'b0;
    logic [7:0] svr_wdata_i = 8'h00;
    logic halt_i = 1'b0;
    logic idle_i = 1'b0;
    logic rc_osc_option_i = 1'b0;
    logic restart_delay_select_i = 1'b0;
    logic fault_pin_i;
    logic fault_pin_o;
    logic fault_pin_oe_o;
    logic [7:0] svr_rdata_o;
    logic [7:0] rnd = 8'h27;
    logic [7:0] bad;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    wwd_top #(.CKI_PER_TC(1), .CM_TIMEOUT_CYC(200)) wwd_top_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .cki_i(cki_i), .svr_wr_i(svr_wr_i), .svr_wdata_i(svr_wdata_i),
        .svr_rdata_o(svr_rdata_o), .halt_i(halt_i), .idle_i(idle_i),
        .rc_osc_option_i(rc_osc_option_i), .restart_delay_select_i(restart_delay_select_i),
        .fault_pin_i(fault_pin_i), .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o));
    wwd_pullup wwd_pullup_i (.drv_i(fault_pin_o), .oe_i(fault_pin_oe_o), .pin_o(fault_pin_i));
    always #2.5 clk_i = ~clk_i;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic exp_fault(input logic [7:0] d, input logic early);
        return early || (d[5:1] != wwd_pkg::SVR_KEY) || ({d[7:6], d[0]} != {CFG[7:6], CFG[0]});
    endfunction
    task automatic wrap_up;
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    always @(posedge clk_i) begin
        if (cki_run) begin
            cki_i <= ~cki_i;
        end
        cyc = cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wr(input logic [7:0] d);
        @(posedge clk_i);
        svr_wr_i <= 1'b1;
        svr_wdata_i <= d;
        @(posedge clk_i);
        svr_wr_i <= 1'b0;
    endtask
    task automatic recover;
        wr(CFG);
        n = 0;
        while (fault_pin_oe_o !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk(fault_pin_oe_o === 1'b0, "pin stuck low");
        repeat (8) @(posedge clk_i);
    endtask
    task automatic trial(input int pre, input int lp, input logic [1:0] mode,
                         input logic [7:0] d, input logic early);
        repeat (pre) @(posedge clk_i);
        if (lp > 0) begin
            halt_i <= mode[0];
            idle_i <= mode[1];
            repeat (lp) @(posedge clk_i);
            halt_i <= 1'b0;
            idle_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        wr(d);
        repeat (3) @(posedge clk_i);
        chk(fault_pin_oe_o === exp_fault(d, early), "service outcome");
        if (exp_fault(d, early)) begin
            recover();
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk(svr_rdata_o === 8'hC1, "reset value");
        trial(0, 0, 2'h0, CFG, 1'b0);
        chk(svr_rdata_o === 8'h01, "config read");
        trial(100, 0, 2'h0, CFG, 1'b1);
        trial(GAP, 0, 2'h0, CFG, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            bad = (i == 0) ? {2'h0, rnd[4:0] | 5'h10, 1'b1} :
                  (i == 1) ? {2'h1, wwd_pkg::SVR_KEY, 1'b1} : {2'h0, wwd_pkg::SVR_KEY, 1'b0};
            trial(GAP + int'(rnd[5:0]), 0, 2'h0, bad, 1'b0);
        end
        chk(svr_rdata_o === 8'h01, "config kept");
        rc_osc_option_i <= 1'b1;
        trial(GAP, 14000, 2'h1, CFG, 1'b0);
        restart_delay_select_i <= 1'b1;
        trial(GAP, 400, 2'h1, CFG, 1'b1);
        rc_osc_option_i <= 1'b0;
        trial(GAP, 400, 2'h2, CFG, 1'b1);
        restart_delay_select_i <= 1'b0;
        trial(GAP, 400, 2'h1, CFG, 1'b1);
        n = 0;
        while (fault_pin_oe_o !== 1'b1 && n < 17000) begin
            @(posedge clk_i);
            n++;
        end
        chk(n > 16300 && n < 16500, "upper limit");
        recover();
        cki_run <= 1'b0;
        repeat (300) @(posedge clk_i);
        chk(fault_pin_oe_o === 1'b1, "clock monitor");
        cki_run <= 1'b1;
        recover();
        // Second reset: configure with the monitor off, then stop the clock
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk(svr_rdata_o === 8'hC1, "reset again");
        wr(8'hD8);
        repeat (2) @(posedge clk_i);
        chk(svr_rdata_o === 8'hC0, "monitor off read");
        cki_run <= 1'b0;
        repeat (300) @(posedge clk_i);
        chk(fault_pin_oe_o === 1'b0, "monitor disabled");
        cki_run <= 1'b1;
        wrap_up();
    end
endmodule
